// File: shared/wsa_map.vh
// Behaviour
// [R1] Wake status records events regardless of enables
// [R2] Wake status cleared only by writing one
// [R3] Wake status one: device,ring,mouse,kbd,ri1,ri2
// [R4] Wake enable one mirrors wake status one
// [R5] Wake register two bit n is input 10+n
// [R6] Enabled source with master enable asserts event
// [R7] Disabled source records status, never asserts event; the code asserts it through the grouped irq when enable two bit 6 is set
// [R8] Grouped irq is OR of enabled sources; the code also ORs in the sleep request flag, which has no enable
// [R9] Enable two bit 7 gates grouped irq out
// [R10] Pin or serial slot chosen by mux input
// [R11] Enable two bit 6 routes irq to wake
// [R12] Irq status one follows sources, cleared there
// [R13] Irq status two bits 0,1,4 follow sources
// [R14] Infrared transition sets bit 2, read clears
// [R15] Bit 3 cleared by reading status two
// [R16] Sleep request sets bit 7, read clears
// [R17] Irq enable bit layouts for both registers
// [R18] Ring irq uses ring wake status bit
// [R19] Enable two bit 4 routes kbc port bit
// [R20] All eight registers reset to zero
// [R21] Master enable gates the wake event output
// [R22] Software writes zero to reserved bits
// [R23] Async inputs synchronised before edge detection
`ifndef WSA_MAP_VH
`define WSA_MAP_VH
`define WSA_OFF_WSTS1 16'h000C
`define WSA_OFF_WSTS2 16'h000D
`define WSA_OFF_WEN1 16'h000E
`define WSA_OFF_WEN2 16'h000F
`define WSA_OFF_ISTS1 16'h0012
`define WSA_OFF_ISTS2 16'h0013
`define WSA_OFF_IEN1 16'h0014
`define WSA_OFF_IEN2 16'h0015
`define WSA_RST_VAL 8'h00
`define WSA_WAKE1_MASK 8'hBE
`define WSA_ISTS1_MASK 8'hFE
`define WSA_IEN2_MASK 8'hDF
`define WSA_BIT_DEVINT 7
`define WSA_BIT_RING 5
`define WSA_BIT_MOUSE 4
`define WSA_BIT_KBD 3
`define WSA_BIT_RI1 2
`define WSA_BIT_RI2 1
`define WSA_BIT_IR 2
`define WSA_BIT_BIT3 3
`define WSA_BIT_KBC 4
`define WSA_BIT_SLEEP 7
`define WSA_BIT_TO_WAKE 6
`define WSA_BIT_OUT_EN 7
`endif

// File: rtl/wsa_sync.v
`timescale 1ns/10ps
module wsa_sync #(
    parameter W = 1
) (
    input wire i_sys_clk,
    input wire i_rst,
    input wire [W-1:0] i_async,
    output reg [W-1:0] o_level,
    output wire [W-1:0] o_rise,
    output wire [W-1:0] o_fall
);
    reg [W-1:0] ff1;
    reg [W-1:0] ff2;
    reg [W-1:0] ff3;
    reg [W-1:0] level_d;
    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : bit_sync
            always @(posedge i_sys_clk) begin
                if (i_rst) begin
                    ff1[g] <= 1'b0;
                    ff2[g] <= 1'b0;
                    ff3[g] <= 1'b0;
                    o_level[g] <= 1'b0;
                    level_d[g] <= 1'b0;
                end else begin
                    ff1[g] <= i_async[g];
                    ff2[g] <= ff1[g];
                    ff3[g] <= ff2[g];
                    // Accept only when second and third stage agree [R23]
                    if (ff2[g] == ff3[g]) begin
                        o_level[g] <= ff3[g];
                    end
                    level_d[g] <= o_level[g];
                end
            end
        end
    endgenerate
    assign o_rise = o_level & ~level_d;
    assign o_fall = ~o_level & level_d;
endmodule

// File: rtl/wsa_sticky.v
`timescale 1ns/10ps
module wsa_sticky #(
    parameter W = 8
) (
    input wire i_sys_clk,
    input wire i_rst,
    input wire [W-1:0] i_set,
    input wire [W-1:0] i_clr,
    output reg [W-1:0] o_flag
);
    // Set beats a clear in the same cycle so no event is lost
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_flag <= {W{1'b0}};
        end else begin
            o_flag <= (o_flag & ~i_clr) | i_set;
        end
    end
endmodule

// File: rtl/wsa_aggregator.v
`timescale 1ns/10ps
`include "wsa_map.vh"
module wsa_aggregator (
    input wire i_sys_clk,
    input wire i_rst,
    input wire [15:0] i_pm_base,
    input wire [15:0] i_io_addr,
    input wire i_io_rd,
    input wire i_io_wr,
    input wire [7:0] i_io_wdata,
    output reg [7:0] o_io_rdata,
    output reg o_io_rvalid,
    input wire i_device_interrupt,
    input wire i_ring_input_n,
    input wire i_mouse_wake,
    input wire i_keyboard_wake,
    input wire i_serial1_ring_indicator,
    input wire i_serial2_ring_indicator,
    input wire [7:0] i_general_input,
    input wire i_parallel_port_irq,
    input wire i_serial2_irq,
    input wire i_serial1_irq,
    input wire i_floppy_irq,
    input wire i_group_irq_two,
    input wire i_group_irq_one,
    input wire i_watchdog_irq,
    input wire i_mouse_irq,
    input wire i_keyboard_irq,
    input wire i_kbc_port_bit_1_2,
    input wire i_ir_rx_a,
    input wire i_ir_rx_b,
    input wire i_ir_rx_select,
    input wire i_bit3_event,
    input wire i_sleep_request,
    input wire i_master_wake_event_enable,
    input wire i_irq_mux_serial,
    output wire o_wake_event_n_out,
    output reg o_wake_event_n_oe,
    output wire o_grouped_sysmgmt_irq_out_n_out,
    output reg o_grouped_sysmgmt_irq_out_n_oe,
    output reg o_serirq_slot_irq2
);
    reg [7:0] wake_enable_one;
    reg [7:0] wake_enable_two;
    reg [7:0] sysmgmt_irq_enable_one;
    reg [7:0] sysmgmt_irq_enable_two;
    wire [7:0] wake_status_one;
    wire [7:0] wake_status_two;
    wire [7:0] sysmgmt_irq_status_one;
    wire [7:0] sysmgmt_irq_status_two;
    wire [15:0] off;
    wire [5:0] wk_async;
    wire [5:0] wk_rise;
    wire [7:0] gp_rise;
    wire [9:0] lv_async;
    wire [9:0] lv;
    wire ir_sel_rx;
    wire ir_edge_r;
    wire ir_edge_f;
    wire [7:0] wake1_set;
    wire [7:0] wake1_clr;
    wire [7:0] wake2_clr;
    wire [7:0] sts2_set;
    wire [7:0] sts2_clr;
    wire rd_sts2;
    wire [7:0] sts2_flags;
    wire group_irq;
    wire wake_any;
    reg [7:0] next_rdata;

    assign off = i_io_addr - i_pm_base;
    // Ring is active low at the pin, so invert before the detector
    assign wk_async = {i_device_interrupt, ~i_ring_input_n, i_mouse_wake,
                       i_keyboard_wake, i_serial1_ring_indicator,
                       i_serial2_ring_indicator}; // [R23]
    wsa_sync #(.W(6)) u_sync_wake (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_async(wk_async),
        .o_level(),
        .o_rise(wk_rise),
        .o_fall()
    );
    wsa_sync #(.W(8)) u_sync_gp (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_async(i_general_input),
        .o_level(),
        .o_rise(gp_rise),
        .o_fall()
    );
    assign lv_async = {i_watchdog_irq, i_group_irq_one, i_group_irq_two,
                       i_floppy_irq, i_serial1_irq, i_serial2_irq,
                       i_parallel_port_irq, i_kbc_port_bit_1_2,
                       i_keyboard_irq, i_mouse_irq};
    wsa_sync #(.W(10)) u_sync_lvl (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_async(lv_async),
        .o_level(lv),
        .o_rise(),
        .o_fall()
    );
    // Pin select happens before the synchroniser [R14]
    assign ir_sel_rx = i_ir_rx_select ? i_ir_rx_b : i_ir_rx_a;
    wsa_sync #(.W(1)) u_sync_ir (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_async(ir_sel_rx),
        .o_level(),
        .o_rise(ir_edge_r),
        .o_fall(ir_edge_f)
    );

    // Events set status whatever the enables say [R1]
    assign wake1_set = {wk_rise[5], 1'b0, wk_rise[4:0], 1'b0}; // [R3]
    assign wake1_clr = (i_io_wr && off == `WSA_OFF_WSTS1) ?
                       (i_io_wdata & `WSA_WAKE1_MASK) : 8'h00; // [R2]
    assign wake2_clr = (i_io_wr && off == `WSA_OFF_WSTS2) ?
                       i_io_wdata : 8'h00; // [R2]
    wsa_sticky #(.W(8)) u_wake1 (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_set(wake1_set),
        .i_clr(wake1_clr),
        .o_flag(wake_status_one)
    );
    // Bit n of the second pair is general input ten plus n [R5]
    wsa_sticky #(.W(8)) u_wake2 (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_set(gp_rise),
        .i_clr(wake2_clr),
        .o_flag(wake_status_two)
    );

    assign rd_sts2 = i_io_rd && off == `WSA_OFF_ISTS2;
    assign sts2_set = {i_sleep_request, 3'b000, i_bit3_event,
                       ir_edge_r | ir_edge_f, 2'b00}; // [R14] [R16]
    // Read clears the event bits; a new event in that cycle survives
    assign sts2_clr = rd_sts2 ? 8'h8C : 8'h00; // [R14] [R15] [R16]
    wsa_sticky #(.W(8)) u_sts2 (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_set(sts2_set),
        .i_clr(sts2_clr),
        .o_flag(sts2_flags)
    );
    // Level bits follow their sources and clear there [R12] [R13]
    assign sysmgmt_irq_status_one = {lv[9:3], 1'b0};
    assign sysmgmt_irq_status_two = {sts2_flags[7], 2'b00, lv[2],
                                     sts2_flags[3:2], lv[1:0]};

    // Reserved bits are stored as zero [R22]
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            wake_enable_one <= `WSA_RST_VAL; // [R20]
            wake_enable_two <= `WSA_RST_VAL;
            sysmgmt_irq_enable_one <= `WSA_RST_VAL;
            sysmgmt_irq_enable_two <= `WSA_RST_VAL;
        end else if (i_io_wr) begin
            if (off == `WSA_OFF_WEN1) begin
                wake_enable_one <= i_io_wdata & `WSA_WAKE1_MASK; // [R4]
            end
            if (off == `WSA_OFF_WEN2) begin
                wake_enable_two <= i_io_wdata; // [R5]
            end
            if (off == `WSA_OFF_IEN1) begin
                sysmgmt_irq_enable_one <= i_io_wdata; // [R17]
            end
            if (off == `WSA_OFF_IEN2) begin
                sysmgmt_irq_enable_two <= i_io_wdata & `WSA_IEN2_MASK;
            end
        end
    end

    always @* begin
        case (off)
            `WSA_OFF_WSTS1: next_rdata = wake_status_one;
            `WSA_OFF_WSTS2: next_rdata = wake_status_two;
            `WSA_OFF_WEN1: next_rdata = wake_enable_one;
            `WSA_OFF_WEN2: next_rdata = wake_enable_two;
            `WSA_OFF_ISTS1: next_rdata = sysmgmt_irq_status_one;
            `WSA_OFF_ISTS2: next_rdata = sysmgmt_irq_status_two;
            `WSA_OFF_IEN1: next_rdata = sysmgmt_irq_enable_one;
            `WSA_OFF_IEN2: next_rdata = sysmgmt_irq_enable_two;
            default: next_rdata = 8'h00;
        endcase
    end

    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_io_rdata <= 8'h00;
            o_io_rvalid <= 1'b0;
        end else begin
            o_io_rvalid <= i_io_rd;
            if (i_io_rd) begin
                o_io_rdata <= next_rdata;
            end
        end
    end

    // Ring has no irq status bit of its own [R18]
    // Sleep request always counts, it exists only to raise the irq
    assign group_irq =
        (wake_status_one[`WSA_BIT_RING] & sysmgmt_irq_enable_one[0]) |
        (|(sysmgmt_irq_status_one[7:1] & sysmgmt_irq_enable_one[7:1])) |
        (|(sysmgmt_irq_status_two[3:0] & sysmgmt_irq_enable_two[3:0])) |
        (lv[2] & sysmgmt_irq_enable_two[`WSA_BIT_KBC]) | // [R19]
        sts2_flags[`WSA_BIT_SLEEP]; // [R8]
    // Wake-disabled sources reach the event output only via the grouped irq when enable two bit 6 is set [R6] [R7]
    assign wake_any = (|(wake_status_one & wake_enable_one)) |
                      (|(wake_status_two & wake_enable_two)) |
                      (group_irq &
                       sysmgmt_irq_enable_two[`WSA_BIT_TO_WAKE]); // [R11]

    assign o_wake_event_n_out = 1'b0;
    assign o_grouped_sysmgmt_irq_out_n_out = 1'b0;
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_wake_event_n_oe <= 1'b0;
            o_grouped_sysmgmt_irq_out_n_oe <= 1'b0;
            o_serirq_slot_irq2 <= 1'b0;
        end else begin
            o_wake_event_n_oe <= wake_any & i_master_wake_event_enable; // [R21]
            // Pin floats when the output enable bit is clear [R9] [R10]
            o_grouped_sysmgmt_irq_out_n_oe <= group_irq & ~i_irq_mux_serial &
                sysmgmt_irq_enable_two[`WSA_BIT_OUT_EN];
            o_serirq_slot_irq2 <= group_irq & i_irq_mux_serial &
                sysmgmt_irq_enable_two[`WSA_BIT_OUT_EN];
        end
    end
endmodule

// File: bench/wsa_chk.sv
`timescale 1ns/10ps
module wsa_chk (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_io_rd,
    input wire logic [7:0] o_io_rdata,
    input wire logic o_io_rvalid,
    input wire logic i_master_wake_event_enable,
    input wire logic i_irq_mux_serial,
    input wire logic o_wake_event_n_out,
    input wire logic o_wake_event_n_oe,
    input wire logic o_grouped_sysmgmt_irq_out_n_out,
    input wire logic o_grouped_sysmgmt_irq_out_n_oe,
    input wire logic o_serirq_slot_irq2
);
    wire mux = i_irq_mux_serial;
    wire pin = o_grouped_sysmgmt_irq_out_n_oe;
    wire slot = o_serirq_slot_irq2;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    a_read_answer: assert property (i_io_rd |=> o_io_rvalid)
        else $error("read strobe not answered");
    a_no_stray_valid: assert property (!i_io_rd |=> !o_io_rvalid)
        else $error("read valid without strobe");
    a_rdata_hold: assert property (!i_io_rd |=> $stable(o_io_rdata))
        else $error("read data moved without a read");
    a_master_gate: assert property
        (!i_master_wake_event_enable |=> !o_wake_event_n_oe)
        else $error("wake output driven while master off");
    a_serial_no_pin: assert property (mux |=> !pin)
        else $error("pin driven while serial slot chosen");
    a_pin_no_slot: assert property (!mux |=> !slot)
        else $error("slot active while pin chosen");
    a_pin_slot_excl: assert property (!(pin && slot))
        else $error("pin and slot active together");
    a_drive_low: assert property (o_wake_event_n_out == 1'b0 &&
        o_grouped_sysmgmt_irq_out_n_out == 1'b0)
        else $error("open drain outputs not driving low");
endmodule

bind wsa_aggregator wsa_chk u_chk (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_io_rd(i_io_rd),
    .o_io_rdata(o_io_rdata), .o_io_rvalid(o_io_rvalid),
    .i_master_wake_event_enable(i_master_wake_event_enable),
    .i_irq_mux_serial(i_irq_mux_serial),
    .o_wake_event_n_out(o_wake_event_n_out),
    .o_wake_event_n_oe(o_wake_event_n_oe),
    .o_grouped_sysmgmt_irq_out_n_out(o_grouped_sysmgmt_irq_out_n_out),
    .o_grouped_sysmgmt_irq_out_n_oe(o_grouped_sysmgmt_irq_out_n_oe),
    .o_serirq_slot_irq2(o_serirq_slot_irq2)
);

// File: bench/wsa_host.sv
`timescale 1ns/10ps
// Host side pulls both shared lines up; any driver pulls low
module wsa_host (
    input wire logic i_wake_oe,
    input wire logic i_smi_oe,
    output logic o_wake_line,
    output logic o_smi_line
);
    assign o_wake_line = i_wake_oe ? 1'b0 : 1'b1;
    assign o_smi_line = i_smi_oe ? 1'b0 : 1'b1;
endmodule

// File: bench/tb_top.sv
`timescale 1ns/10ps
`include "wsa_map.vh"
module tb_top;
    logic i_sys_clk = 0, i_rst = 1, rd = 0, wr = 0, dev = 0, rng_n = 1;
    logic mou = 0, kbd = 0, ri1 = 0, ri2 = 0, par = 0, s2 = 0, s1 = 0;
    logic fl = 0, g2 = 0, g1 = 0, wdt = 0, mi = 0, ki = 0, kbc = 0;
    logic ira = 0, irb = 0, irsel = 0, b3 = 0, slp = 0, mst = 0, mux = 0;
    logic [15:0] adr = 0;
    logic [7:0] wd = 0, gp = 0, rdat;
    logic rv, woe, soe, slot, wln, sln;
    int num_errors = 0, checked = 0, cyc = 0;
    localparam logic [15:0] BASE = 16'h0400;

    wsa_aggregator dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .i_pm_base(BASE), .i_io_addr(adr), .i_io_rd(rd), .i_io_wr(wr),
        .i_io_wdata(wd), .o_io_rdata(rdat), .o_io_rvalid(rv),
        .i_device_interrupt(dev), .i_ring_input_n(rng_n),
        .i_mouse_wake(mou), .i_keyboard_wake(kbd),
        .i_serial1_ring_indicator(ri1), .i_serial2_ring_indicator(ri2),
        .i_general_input(gp), .i_parallel_port_irq(par),
        .i_serial2_irq(s2), .i_serial1_irq(s1), .i_floppy_irq(fl),
        .i_group_irq_two(g2), .i_group_irq_one(g1), .i_watchdog_irq(wdt),
        .i_mouse_irq(mi), .i_keyboard_irq(ki), .i_kbc_port_bit_1_2(kbc),
        .i_ir_rx_a(ira), .i_ir_rx_b(irb), .i_ir_rx_select(irsel),
        .i_bit3_event(b3), .i_sleep_request(slp),
        .i_master_wake_event_enable(mst), .i_irq_mux_serial(mux),
        .o_wake_event_n_out(), .o_wake_event_n_oe(woe),
        .o_grouped_sysmgmt_irq_out_n_out(),
        .o_grouped_sysmgmt_irq_out_n_oe(soe), .o_serirq_slot_irq2(slot));
    wsa_host host (.i_wake_oe(woe), .i_smi_oe(soe), .o_wake_line(wln),
        .o_smi_line(sln));

    always #25 i_sys_clk = ~i_sys_clk;

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            end_of_test();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask

    // Reserved bits always written as zero by every caller
    task automatic wrr(input logic [15:0] off, input logic [7:0] d);
        tick(1);
        adr = BASE + off;
        wd = d;
        wr = 1;
        tick(1);
        wr = 0;
    endtask

    task automatic rdr(input logic [15:0] off, input logic [7:0] exp);
        tick(1);
        adr = BASE + off;
        rd = 1;
        tick(1);
        rd = 0;
        chk(rv, 1);
        chk(rdat, exp);
    endtask

    task automatic t_reset;
        logic [15:0] offs[9] = '{16'h000C, 16'h000D, 16'h000E, 16'h000F,
            16'h0012, 16'h0013, 16'h0014, 16'h0015, 16'h0010};
        foreach (offs[i]) rdr(offs[i], 8'h00);
        chk(wln, 1);
        chk(sln, 1);
        $display("reset test done");
    endtask

    task automatic t_wake;
        mst = 1;
        wrr(`WSA_OFF_WEN1, 8'h08);
        rdr(`WSA_OFF_WEN1, 8'h08);
        mou = 1;
        kbd = 1;
        tick(8);
        rdr(`WSA_OFF_WSTS1, 8'h18);
        chk(wln, 0);
        wrr(`WSA_OFF_WSTS1, 8'h00);
        rdr(`WSA_OFF_WSTS1, 8'h18);
        mst = 0;
        tick(3);
        chk(wln, 1);
        mst = 1;
        wrr(`WSA_OFF_WSTS1, 8'h08);
        rdr(`WSA_OFF_WSTS1, 8'h10);
        tick(2);
        chk(wln, 1);
        gp = 8'h80;
        tick(8);
        rdr(`WSA_OFF_WSTS2, 8'h80);
        wrr(`WSA_OFF_WEN2, 8'h80);
        tick(3);
        chk(wln, 0);
        wrr(`WSA_OFF_WSTS2, 8'h80);
        wrr(`WSA_OFF_WSTS1, 8'h10);
        tick(3);
        chk(wln, 1);
        $display("wake test done");
    endtask

    task automatic t_smi;
        wrr(`WSA_OFF_IEN1, 8'h02);
        wrr(`WSA_OFF_IEN2, 8'h80);
        par = 1;
        tick(8);
        rdr(`WSA_OFF_ISTS1, 8'h02);
        chk(sln, 0);
        mux = 1;
        tick(3);
        chk(sln, 1);
        chk(slot, 1);
        mux = 0;
        wrr(`WSA_OFF_IEN2, 8'h00);
        tick(3);
        chk(sln, 1);
        par = 0;
        tick(8);
        rdr(`WSA_OFF_ISTS1, 8'h00);
        rng_n = 0;
        tick(8);
        rdr(`WSA_OFF_WSTS1, 8'h20);
        chk(wln, 1);
        wrr(`WSA_OFF_IEN1, 8'h01);
        wrr(`WSA_OFF_IEN2, 8'h40);
        tick(3);
        chk(wln, 0);
        wrr(`WSA_OFF_IEN2, 8'h00);
        tick(3);
        chk(wln, 1);
        wrr(`WSA_OFF_WSTS1, 8'h20);
        kbc = 1;
        wrr(`WSA_OFF_IEN2, 8'h90);
        tick(8);
        rdr(`WSA_OFF_ISTS2, 8'h10);
        chk(sln, 0);
        wrr(`WSA_OFF_IEN2, 8'h80);
        tick(3);
        chk(sln, 1);
        $display("grouped irq test done");
    endtask

    task automatic t_rdclr;
        irsel = 1;
        irb = 1;
        slp = 1;
        tick(1);
        slp = 0;
        b3 = 1;
        tick(1);
        b3 = 0;
        tick(8);
        chk(sln, 0);
        rdr(`WSA_OFF_ISTS2, 8'h9C);
        rdr(`WSA_OFF_ISTS2, 8'h10);
        ira = 1;
        tick(8);
        rdr(`WSA_OFF_ISTS2, 8'h10);
        irsel = 0;
        tick(8);
        ira = 0;
        tick(8);
        rdr(`WSA_OFF_ISTS2, 8'h14);
        $display("read clear test done");
    endtask

    initial begin
        tick(8);
        i_rst = 0;
        t_reset();
        t_wake();
        t_smi();
        t_rdclr();
        end_of_test();
    end
endmodule
